// *** rtl/fbn_pkg.sv ***
// shared constants for the fieldbus node start-up and mapping block
package fbn_pkg;

   // timing
   localparam int CLK_NS = 100;
   localparam int BLINK_NS = 250_000_000;
   localparam int BLINK_CYC = BLINK_NS / CLK_NS;
   localparam int SYNC_STAGES = 2;

   // switch positions (switch n is bit n-1)
   localparam int SW_BAUD_125 = 2;
   localparam int SW_STORE = 7;
   localparam logic [2:0] BAUD_125K = 3'h3;
   localparam logic [2:0] BAUD_RST = 3'h0;

   // fixed CAN identifiers
   localparam logic [10:0] ID_NMT = 11'h000;
   localparam logic [10:0] ID_SYNC = 11'h080;
   localparam logic [10:0] ID_SDO_RX = 11'h600;
   localparam logic [10:0] ID_SDO_TX = 11'h580;
   localparam logic [10:0] ID_TPDO2 = 11'h280;

   // NMT command specifiers
   localparam logic [7:0] NMT_START = 8'h01;
   localparam logic [7:0] NMT_PREOP = 8'h80;

   // SDO command bytes
   localparam logic [7:0] SDO_WR4 = 8'h23;
   localparam logic [7:0] SDO_WR2 = 8'h2B;
   localparam logic [7:0] SDO_WR1 = 8'h2F;
   localparam logic [7:0] SDO_ACK = 8'h60;
   localparam logic [7:0] SDO_ABORT = 8'h80;
   localparam logic [31:0] ABORT_STATE = 32'h0800_0022;
   localparam logic [31:0] ABORT_OBJ = 32'h0602_0000;
   localparam logic [31:0] ABORT_MAP = 32'h0604_0042;

   // object dictionary
   localparam logic [15:0] OBJ_AIN_EN = 16'h6423;
   localparam logic [15:0] OBJ_TPDO2_COM = 16'h1801;
   localparam logic [15:0] OBJ_TPDO2_MAP = 16'h1A01;
   localparam logic [15:0] OBJ_AIN = 16'h2400;
   localparam logic [15:0] OBJ_DIN = 16'h2000;
   localparam logic [7:0] LEN_AIN = 8'h10;
   localparam logic [7:0] LEN_DIN = 8'h08;
   localparam int PDO_MAX_BITS = 64;
   localparam int MAP_ENTRIES = 8;
   localparam logic [31:0] COB_INVALID = 32'h8000_0000;

   // reset values
   localparam logic [7:0] TTYPE_RST = 8'hFF;
   localparam logic [3:0] MAPCNT_RST = 4'h0;

   // APB register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STATUS = 8'h04;
   localparam logic [7:0] A_COBID = 8'h08;
   localparam logic [7:0] A_PDOCFG = 8'h0C;
   localparam logic [7:0] A_AIN_SNAP = 8'h10;

   typedef enum logic [2:0] {
      ST_POR,
      ST_BAUD,
      ST_INIT,
      ST_PREOP,
      ST_OP
   } fbn_state_e;

endpackage : fbn_pkg

// *** rtl/fbn_startup.sv ***
// start-up, NMT state machine and SDO object handling of a CANopen coupler node
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - all switches off at power-up enters baud check-and-set mode
// - baud mode blinks the current bit rate on upper indicators
// - any switch on at power-up: switches become node identifier
// - switch 3 on in baud mode selects 125 kB, shown blinking
// - switch 8 also on stores the selected rate persistently
// - switches are sampled at power-up; switch 1 alone gives node 1
// - power-up enters initialization, builds image, loads default map unless stored
// - fault-free initialization moves on its own to pre-operational
// - SDO accesses accepted in pre-operational and operational
// - start-remote-node moves pre-operational to operational, PDOs begin
// - analog transmit enable 0x6423 resets false; no analog data in PDOs
// - while disabled analog data is captured once, never updated
// - writing 1 to 0x6423 enables analog PDOs once operational
// - mapping changes only in pre-operational; enter-preop command returns there
// - master invalidates PDO via 0x80000000 to 0x1801 sub 1 first
// - master then zeroes entry count at 0x1A01 sub 0
// - entries hold index, sub-index, bit length; total at most 8 bytes
// - lengths in bits: 0x10 analog channel, 0x08 digital group
// - SDO requests on 0x600+node, answers on 0x580+node
// - expedited write 0x23 answered 0x60 with echoed index, sub-index
// - transmission type 3 sends on every third SYNC
// - valid identifier to com sub 1 sets identifier and revalidates PDO
module fbn_startup #(
   parameter int NAIN = 8,
   parameter int NDIN = 4,
   parameter int BLINK_CYC = fbn_pkg::BLINK_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] dip_sw,
   input wire logic [2:0] baud_nv,
   input wire logic pi_ready,
   input wire logic pi_fault,
   input wire logic cfg_stored,
   input wire logic [NAIN*16-1:0] ain_in,
   input wire logic [NDIN*8-1:0] din_in,
   input wire logic rx_valid,
   input wire logic [10:0] rx_id,
   input wire logic [63:0] rx_data,
   output logic tx_valid,
   output logic [10:0] tx_id,
   output logic [3:0] tx_dlc,
   output logic [63:0] tx_data,
   output logic [3:0] led_upper,
   output logic [2:0] baud_sel,
   output logic baud_store,
   output logic [6:0] node_id,
   output logic [2:0] nmt_state
);

   // all block state, registered in one place
   typedef struct packed {
      logic [7:0] sw_m;
      logic [7:0] sw_s;
      logic [1:0] por_cnt;
      fbn_pkg::fbn_state_e st;
      logic [6:0] node;
      logic [2:0] baud;
      logic baud_done;
      logic [31:0] blink_cnt;
      logic blink;
      logic [3:0] led;
      logic store;
      logic ain_en;
      logic snap_done;
      logic [NAIN-1:0][15:0] ain;
      logic [31:0] cob;
      logic [7:0] ttype;
      logic [15:0] inhibit;
      logic [3:0] map_cnt;
      logic [fbn_pkg::MAP_ENTRIES-1:0][31:0] map;
      logic [7:0] sync_cnt;
      logic pdo_pend;
      logic tx_v;
      logic [10:0] tx_i;
      logic [3:0] tx_l;
      logic [63:0] tx_d;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } fbn_reg_s;

   fbn_reg_s q;
   fbn_reg_s d;

   // decode helpers, driven by the two comb processes
   logic [63:0] pay;
   logic [6:0] off;
   logic ana_mapped;
   logic [7:0] cmd;
   logic [15:0] idx;
   logic [7:0] sub;
   logic [31:0] val;
   logic sdo_hit;
   logic sdo_ok;
   logic [31:0] abort;
   logic [7:0] bits;
   logic [31:0] ent;

   ////////////////////////////////////////////////////////////////////////////
   // payload of the transmit PDO from the current mapping
   always_comb begin
      pay = '0;
      off = '0;
      ana_mapped = 1'b0;
      // entries packed lsb first in order
      for (int i = 0; i < fbn_pkg::MAP_ENTRIES; i++) begin
         ent = q.map[i];
         if (4'(i) < q.map_cnt) begin
            if (ent[31:16] == fbn_pkg::OBJ_AIN) begin
               pay = pay | (64'(q.ain[ent[15:8] - 8'h01]) << off);
               ana_mapped = 1'b1;
            end else begin
               pay = pay | (64'(din_in[(ent[15:8] - 8'h01) * 8 +: 8]) << off);
            end
            off = off + ent[6:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      d = q;
      cmd = rx_data[7:0];
      idx = rx_data[23:8];
      sub = rx_data[31:24];
      val = rx_data[63:32];
      sdo_ok = 1'b0;
      abort = fbn_pkg::ABORT_OBJ;
      bits = '0;
      // narrow expedited writes zero the unused bytes
      if (cmd == fbn_pkg::SDO_WR2) begin
         val = {16'h0000, rx_data[47:32]};
      end else if (cmd == fbn_pkg::SDO_WR1) begin
         val = {24'h000000, rx_data[39:32]};
      end
      // own sdo request identifier, valid states only
      sdo_hit = rx_valid && (rx_id == fbn_pkg::ID_SDO_RX + 11'(q.node)) && (q.node != 7'h00)
         && (q.st == fbn_pkg::ST_PREOP || q.st == fbn_pkg::ST_OP);

      // two-stage sync of the switch pins
      d.sw_m = dip_sw;
      d.sw_s = q.sw_m;
      // one-cycle strobes
      d.tx_v = 1'b0;
      d.store = 1'b0;

      case (q.st)
         fbn_pkg::ST_POR: begin
            // wait for the switch sync to settle
            d.por_cnt = q.por_cnt + 2'h1;
            if (q.por_cnt == 2'(fbn_pkg::SYNC_STAGES)) begin
               d.baud = baud_nv;
               d.node = q.sw_s[6:0];
               if (q.sw_s == 8'h00) begin
                  d.st = fbn_pkg::ST_BAUD;
               end else begin
                  d.st = fbn_pkg::ST_INIT;
               end
            end
         end
         fbn_pkg::ST_BAUD: begin
            // only the first selection counts until reset
            if (q.sw_s[fbn_pkg::SW_BAUD_125] && !q.baud_done) begin
               d.baud = fbn_pkg::BAUD_125K;
            end
            if (q.sw_s[fbn_pkg::SW_STORE] && !q.baud_done) begin
               d.store = 1'b1;
               d.baud_done = 1'b1;
            end
            // half-period blink counter
            d.blink_cnt = q.blink_cnt + 32'h1;
            if (q.blink_cnt >= 32'(BLINK_CYC - 1)) begin
               d.blink_cnt = '0;
               d.blink = !q.blink;
            end
            d.led = q.blink ? {1'b1, q.baud} : 4'h0;
         end
         fbn_pkg::ST_INIT: begin
            // default mapping unless a stored config exists
            if (!cfg_stored) begin
               d.cob = {21'h000000, fbn_pkg::ID_TPDO2 + 11'(q.node)};
               d.ttype = fbn_pkg::TTYPE_RST;
               d.map_cnt = fbn_pkg::MAPCNT_RST;
            end
            if (pi_ready && !pi_fault) begin
               d.ain = ain_in;
               d.snap_done = 1'b1;
               d.st = fbn_pkg::ST_PREOP;
            end
         end
         fbn_pkg::ST_PREOP, fbn_pkg::ST_OP: begin
            d.led = {q.st == fbn_pkg::ST_OP, 3'h0};
            // nmt frames, broadcast or own node
            if (rx_valid && rx_id == fbn_pkg::ID_NMT
                && (rx_data[15:8] == 8'h00 || rx_data[14:8] == q.node)) begin
               if (cmd == fbn_pkg::NMT_START) begin
                  d.st = fbn_pkg::ST_OP;
                  d.sync_cnt = '0;
               end else if (cmd == fbn_pkg::NMT_PREOP) begin
                  d.st = fbn_pkg::ST_PREOP;
                  d.pdo_pend = 1'b0;
               end
            end
            // sync counting only with a valid pdo
            if (rx_valid && rx_id == fbn_pkg::ID_SYNC && q.st == fbn_pkg::ST_OP
                && !q.cob[31] && q.ttype != 8'h00 && q.ttype <= 8'd240) begin
               d.sync_cnt = q.sync_cnt + 8'h01;
               if (q.sync_cnt + 8'h01 >= q.ttype) begin
                  d.sync_cnt = '0;
                  d.pdo_pend = !(ana_mapped && !q.ain_en);
               end
            end
         end
         default: begin
            d.st = fbn_pkg::ST_POR;
         end
      endcase

      // live analog data only while enabled
      if (q.ain_en && q.snap_done) begin
         d.ain = ain_in;
      end

      // SDO expedited write decode
      if (sdo_hit) begin
         if (cmd == fbn_pkg::SDO_WR4 || cmd == fbn_pkg::SDO_WR2 || cmd == fbn_pkg::SDO_WR1) begin
            if (idx == fbn_pkg::OBJ_AIN_EN && sub == 8'h00) begin
               d.ain_en = val[0];
               sdo_ok = 1'b1;
            end else if (idx == fbn_pkg::OBJ_TPDO2_COM) begin
               if (sub == 8'h01) begin
                  d.cob = val;
                  sdo_ok = 1'b1;
               end else if (sub == 8'h02) begin
                  d.ttype = val[7:0];
                  sdo_ok = 1'b1;
               end else if (sub == 8'h03) begin
                  d.inhibit = val[15:0];
                  sdo_ok = 1'b1;
               end
            end else if (idx == fbn_pkg::OBJ_TPDO2_MAP) begin
               if (q.st != fbn_pkg::ST_PREOP || !q.cob[31]) begin
                  abort = fbn_pkg::ABORT_STATE;
               end else if (sub == 8'h00) begin
                  // sum of the bit lengths being enabled
                  for (int i = 0; i < fbn_pkg::MAP_ENTRIES; i++) begin
                     if (i < int'(val[3:0])) begin
                        bits = bits + q.map[i][7:0];
                     end
                  end
                  if (val[7:0] <= 8'(fbn_pkg::MAP_ENTRIES) && int'(bits) <= fbn_pkg::PDO_MAX_BITS) begin
                     d.map_cnt = val[3:0];
                     sdo_ok = 1'b1;
                  end else begin
                     abort = fbn_pkg::ABORT_MAP;
                  end
               end else if (sub <= 8'(fbn_pkg::MAP_ENTRIES) && q.map_cnt == 4'h0) begin
                  // entries editable only with count zero
                  if ((val[31:16] == fbn_pkg::OBJ_AIN && val[7:0] == fbn_pkg::LEN_AIN
                       && val[15:8] != 8'h00 && val[15:8] <= 8'(NAIN))
                      || (val[31:16] == fbn_pkg::OBJ_DIN && val[7:0] == fbn_pkg::LEN_DIN
                       && val[15:8] != 8'h00 && val[15:8] <= 8'(NDIN))) begin
                     d.map[sub[2:0] - 3'h1] = val;
                     sdo_ok = 1'b1;
                  end else begin
                     abort = fbn_pkg::ABORT_MAP;
                  end
               end else begin
                  abort = fbn_pkg::ABORT_STATE;
               end
            end
         end
         // sdo reply beats a pending pdo
         d.tx_v = 1'b1;
         d.tx_i = fbn_pkg::ID_SDO_TX + 11'(q.node);
         d.tx_l = 4'h8;
         if (sdo_ok) begin
            d.tx_d = {32'h00000000, sub, idx, fbn_pkg::SDO_ACK};
         end else begin
            // abort carries the code chosen above
            d.tx_d = {abort, sub, idx, fbn_pkg::SDO_ABORT};
         end
      end else if (q.pdo_pend) begin
         // pdo frame from the live mapping
         d.pdo_pend = 1'b0;
         d.tx_v = 1'b1;
         d.tx_i = q.cob[10:0];
         d.tx_l = 4'(off >> 3);
         d.tx_d = pay;
      end


      ////////////////////////////////////////////////////////////////////////
      // apb slave, zero wait states, reply prepared in the setup cycle
      d.pready = psel && !penable;
      d.pslverr = 1'b0;
      d.prdata = '0;
      if (psel && !penable) begin
         case (paddr)
            fbn_pkg::A_CTRL: d.prdata = {31'h0, q.ain_en};
            fbn_pkg::A_STATUS: d.prdata = {12'h000, q.baud_done, q.baud, 1'b0, q.node, q.map_cnt, 1'b0, q.st};
            fbn_pkg::A_COBID: d.prdata = q.cob;
            fbn_pkg::A_PDOCFG: d.prdata = {q.inhibit, q.ttype, q.sync_cnt};
            fbn_pkg::A_AIN_SNAP: d.prdata = {16'h0000, q.ain[0]};
            default: d.pslverr = 1'b1;
         endcase
      end
      if (psel && penable && pwrite && q.pready && paddr == fbn_pkg::A_CTRL && !sdo_hit) begin
         d.ain_en = pwdata[0];
      end

      // clock enable low holds every bit
      if (!clk_en) begin
         d = q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // reset values of the object dictionary
         q <= '0;
         q.st <= fbn_pkg::ST_POR;
         q.baud <= fbn_pkg::BAUD_RST;
         q.ain_en <= 1'b0;
         q.cob <= fbn_pkg::COB_INVALID;
         q.ttype <= fbn_pkg::TTYPE_RST;
         q.map_cnt <= fbn_pkg::MAPCNT_RST;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from the state register
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign tx_valid = q.tx_v;
   assign tx_id = q.tx_i;
   assign tx_dlc = q.tx_l;
   assign tx_data = q.tx_d;
   assign led_upper = q.led;
   assign baud_sel = q.baud;
   assign baud_store = q.store;
   assign node_id = q.node;
   assign nmt_state = q.st;

endmodule : fbn_startup

`default_nettype wire

// *** dv/fbn_startup_assertions.sv ***
// concurrent checks on the node start-up block ports
`timescale 1ns/1ps
`default_nettype none
module fbn_startup_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic pi_ready,
   input wire logic pi_fault,
   input wire logic rx_valid,
   input wire logic [10:0] rx_id,
   input wire logic [63:0] rx_data,
   input wire logic tx_valid,
   input wire logic [10:0] tx_id,
   input wire logic [3:0] tx_dlc,
   input wire logic [63:0] tx_data,
   input wire logic baud_store,
   input wire logic [6:0] node_id,
   input wire logic [2:0] nmt_state
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_sdo_req;
      rx_valid && rx_id == fbn_pkg::ID_SDO_RX + node_id && nmt_state inside {3'h3, 3'h4} && node_id != 7'h00;
   endsequence
   sequence s_sdo_reply;
      tx_valid && tx_id == fbn_pkg::ID_SDO_TX + node_id && tx_dlc == 4'h8;
   endsequence
   sequence s_nmt(logic [7:0] cmd, logic [2:0] st);
      rx_valid && rx_id == fbn_pkg::ID_NMT && rx_data[7:0] == cmd && nmt_state == st
         && (rx_data[15:8] == 8'h00 || rx_data[14:8] == node_id);
   endsequence
   chk_sdo_reply: assert property (s_sdo_req |=> s_sdo_reply)
      else $error("no reply on answer identifier");
   chk_ack_echo: assert property (s_sdo_req |=> tx_data[31:8] == $past(rx_data[31:8]))
      else $error("reply does not echo index and sub-index");
   chk_start_op: assert property (s_nmt(fbn_pkg::NMT_START, 3'h3) |=> nmt_state == 3'h4)
      else $error("start command did not reach operational");
   chk_enter_pre: assert property (s_nmt(fbn_pkg::NMT_PREOP, 3'h4) |=> nmt_state == 3'h3)
      else $error("enter command did not reach pre-operational");
   chk_baud_mode: assert property (nmt_state == 3'h1 |-> node_id == 7'h00)
      else $error("baud mode with nonzero node");
   chk_fault_hold: assert property (nmt_state == 3'h2 && pi_fault |=> nmt_state == 3'h2)
      else $error("left initialization despite fault");
   chk_auto_preop: assert property (nmt_state == 3'h2 && pi_ready && !pi_fault |-> ##[1:16] nmt_state == 3'h3)
      else $error("initialization did not finish");
   chk_early_quiet: assert property (nmt_state inside {3'h0, 3'h1, 3'h2} |-> !tx_valid)
      else $error("frame sent before pre-operational");
   chk_store_mode: assert property (baud_store |-> nmt_state == 3'h1)
      else $error("rate stored outside baud mode");
   chk_apb_unmapped: assert property (psel && !penable && paddr > 8'h10 |=> pready && pslverr)
      else $error("unmapped access not refused");
endmodule : fbn_startup_assertions
bind fbn_startup fbn_startup_assertions chk (.*);
`default_nettype wire

// *** dv/fbn_can_master.sv ***
// CAN master model feeding received frames to the node
`timescale 1ns/1ps
`default_nettype none
module fbn_can_master (
   input wire logic pclk,
   output logic rx_valid,
   output logic [10:0] rx_id,
   output logic [63:0] rx_data
);
   initial begin
      rx_valid = 1'b0;
      rx_id = 11'h7FF;
      rx_data = 64'h0;
   end
   // one frame per call; payload scrambled once released
   task automatic send(input logic [10:0] id, input logic [63:0] data);
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_id <= id;
      rx_data <= data;
      @(posedge pclk);
      rx_valid <= 1'b0;
      rx_data <= ~data;
   endtask : send
endmodule : fbn_can_master
`default_nettype wire

// *** dv/fieldbus_node_startup_mapping_bench.sv ***
// self-checking bench for the node start-up block
`timescale 1ns/1ps
`default_nettype none
module fieldbus_node_startup_mapping_bench;
   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, pi_ready, pi_fault, cfg_stored;
   logic rx_valid, tx_valid, baud_store, se;
   logic [7:0] paddr, dip_sw;
   logic [31:0] pwdata, prdata, din_in, rd;
   logic [2:0] baud_nv, baud_sel, nmt_state;
   logic [127:0] ain_in;
   logic [10:0] rx_id, tx_id;
   logic [63:0] rx_data, tx_data;
   logic [3:0] tx_dlc, led_upper;
   logic [6:0] node_id;
   int err_count, checks_done, tx_cnt, st_cnt, snap;
   fbn_startup #(.BLINK_CYC(4)) dut (.*);
   fbn_can_master master (.pclk(pclk), .rx_valid(rx_valid), .rx_id(rx_id), .rx_data(rx_data));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (tx_valid === 1'b1) tx_cnt++;
      if (baud_store === 1'b1) st_cnt++;
   end
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) err_count++;
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic get_tx;
      int n;
      n = 0;
      #1;
      while (tx_valid !== 1'b1 && n < 40) begin
         @(posedge pclk);
         #1;
         n++;
      end
      if (tx_valid !== 1'b1) err_count++;
   endtask : get_tx
   task automatic sdo(input logic [63:0] d, input logic [7:0] resp);
      master.send(11'h608, d);
      get_tx();
      check("sdo reply", {tx_id, tx_data[31:0]}, {11'h588, d[31:8], resp});
   endtask : sdo
   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5000) @(posedge pclk);
      err_count++;
      finish_test();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, baud_nv, cfg_stored} = '0;
      {clk_en, pi_ready, pi_fault} = 3'h7;
      dip_sw = 8'h08;
      ain_in = 128'h7777_6666_5555_4444_3333_2222_1111_0ABC;
      din_in = 32'h1234_56C3;
      {err_count, checks_done, tx_cnt, st_cnt} = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (12) @(posedge pclk);
      check("init hold", nmt_state, 3'h2);
      pi_fault <= 1'b0;
      repeat (20) @(posedge pclk);
      check("auto preop", nmt_state, 3'h3);
      check("node id", node_id, 7'h08);
      apb(1'b0, fbn_pkg::A_CTRL, 32'h0);
      check("ain enable reset", rd, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      check("unmapped error", se, 1'b1);
      apb(1'b1, fbn_pkg::A_CTRL, 32'h1);
      apb(1'b0, fbn_pkg::A_CTRL, 32'h0);
      check("ain enable", rd, 32'h1);
      sdo(64'h8000_0000_0118_0123, 8'h60);
      sdo(64'h0000_0000_001A_012F, 8'h60);
      sdo(64'h2400_0310_011A_0123, 8'h60);
      sdo(64'h2400_0510_021A_0123, 8'h60);
      sdo(64'h2000_0108_031A_0123, 8'h60);
      sdo(64'h0000_0003_001A_012F, 8'h60);
      apb(1'b0, fbn_pkg::A_STATUS, 32'h0);
      check("map count", rd[7:4], 4'h3);
      sdo(64'h0000_0003_0218_012F, 8'h60);
      sdo(64'h0000_0432_0118_0123, 8'h60);
      master.send(fbn_pkg::ID_NMT, 64'h0801);
      repeat (2) @(posedge pclk);
      check("operational", nmt_state, 3'h4);
      sdo(64'h0000_0000_001A_012F, fbn_pkg::SDO_ABORT);
      repeat (2) @(posedge pclk);
      snap = tx_cnt;
      master.send(fbn_pkg::ID_SYNC, 64'h0);
      master.send(fbn_pkg::ID_SYNC, 64'h0);
      repeat (4) @(posedge pclk);
      check("no pdo before third sync", tx_cnt, snap);
      master.send(fbn_pkg::ID_SYNC, 64'h0);
      get_tx();
      check("pdo", {tx_id, tx_dlc, tx_data[39:0]}, {11'h432, 4'h5, din_in[7:0], ain_in[79:64], ain_in[47:32]});
      master.send(fbn_pkg::ID_NMT, 64'h0880);
      repeat (2) @(posedge pclk);
      check("back to preop", nmt_state, 3'h3);
      presetn <= 1'b0;
      dip_sw <= 8'h00;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (10) @(posedge pclk);
      check("baud mode", nmt_state, 3'h1);
      dip_sw <= 8'h04;
      repeat (10) @(posedge pclk);
      check("baud 125k", baud_sel, fbn_pkg::BAUD_125K);
      snap = 0;
      repeat (12) begin
         @(posedge pclk);
         if (led_upper === {1'b1, fbn_pkg::BAUD_125K}) snap++;
      end
      check("blink 125k", snap > 0, 1'b1);
      dip_sw <= 8'h84;
      repeat (10) @(posedge pclk);
      check("one store pulse", st_cnt, 1);
      finish_test();
   end
endmodule : fieldbus_node_startup_mapping_bench
`default_nettype wire
